// ---- hw/jcb_pkg.sv ----
/*
  Constants, types and carriers for the configuration loader and scan port.
  Assumes one core clock domain and a test clock domain supplied by the programmer.
*/
package jcb_pkg;
  localparam int IO_N     = 80;
  localparam int DED_N    = 4;
  localparam int CELL_N   = IO_N + DED_N;
  localparam int CAP_W    = 3;
  localparam int CHAIN_W  = CELL_N * CAP_W;
  localparam int IR_W     = 4;
  localparam int DR_W     = 32;
  localparam int SIG_W    = 16;
  localparam int CNT_W    = 4;
  localparam logic [CNT_W-1:0] INIT_LAST = 4'h7;
  localparam int CFG_TAPEN_BIT = 0;
  localparam int CFG_PUTMS_BIT = 1;
  localparam int CFG_PUTDI_BIT = 2;
  localparam logic [DR_W-1:0]  CFG_ERASED = 32'hFFFFFFFF;
  localparam logic [SIG_W-1:0] SIG_ERASED = 16'hFFFF;
  localparam logic [IR_W-1:0] IR_CAPTURE  = 4'h1;
  localparam logic [IR_W-1:0] IR_EXTEST   = 4'h0;
  localparam logic [IR_W-1:0] IR_SAMPLE   = 4'h1;
  localparam logic [IR_W-1:0] IR_IDCODE   = 4'h2;
  localparam logic [IR_W-1:0] IR_HIGHZ    = 4'h3;
  localparam logic [IR_W-1:0] IR_ENABLE   = 4'h4;
  localparam logic [IR_W-1:0] IR_PROG     = 4'h5;
  localparam logic [IR_W-1:0] IR_DRLOAD   = 4'h6;
  localparam logic [IR_W-1:0] IR_ERASE    = 4'h7;
  localparam logic [IR_W-1:0] IR_FUSE     = 4'h8;
  localparam logic [IR_W-1:0] IR_DONE     = 4'h9;
  localparam logic [IR_W-1:0] IR_READ     = 4'hA;
  localparam logic [IR_W-1:0] IR_SIGWR    = 4'hB;
  localparam logic [IR_W-1:0] IR_SIGRD    = 4'hC;
  localparam logic [IR_W-1:0] IR_BYPASS   = 4'hF;

  typedef enum logic [3:0] {
    TAP_RESET = 4'b0000, TAP_IDLE  = 4'b0001, TAP_SELDR = 4'b0010, TAP_CAPDR = 4'b0011,
    TAP_SHDR  = 4'b0100, TAP_EX1DR = 4'b0101, TAP_PSDR  = 4'b0110, TAP_EX2DR = 4'b0111,
    TAP_UPDR  = 4'b1000, TAP_SELIR = 4'b1001, TAP_CAPIR = 4'b1010, TAP_SHIR  = 4'b1011,
    TAP_EX1IR = 4'b1100, TAP_PSIR  = 4'b1101, TAP_EX2IR = 4'b1110, TAP_UPIR  = 4'b1111
  } jcb_tap_t;

  typedef enum logic [0:0] {CORE_INIT = 1'b0, CORE_RUN = 1'b1} jcb_core_t;

  typedef struct packed {
    logic [IR_W-1:0] op;
    logic [DR_W-1:0] data;
  } jcb_cmd_t;

  typedef struct packed {
    logic               rstS1, rstS2, tapEnS1, tapEnS2, ackS1, ackS2;
    logic [CHAIN_W-1:0] smp1, smp2, bsr;
    logic [IO_N-1:0]    updOut, updOe;
    jcb_tap_t           tap;
    logic [IR_W-1:0]    irSh, ir;
    logic [DR_W-1:0]    dr;
    logic               byp, reqTgl, abortTgl;
    jcb_cmd_t           cmd;
  } jcb_tck_st_t;

  typedef struct packed {
    logic             reqS1, reqS2, reqPrev, abS1, abS2, abPrev, ackTgl;
    jcb_core_t        core;
    logic [CNT_W-1:0] cnt;
    logic [DR_W-1:0]  nvMem, cfg, rdWord;
    logic [SIG_W-1:0] nvSig;
    logic             nvFuse, nvBusy, sess, live_reprogram_mode;
  } jcb_ref_st_t;
endpackage

// ---- hw/jcb_config_tap.sv ----
/*
  Configuration loader with security fuse, live reprogram, direct register load,
  programming lockout and a four-wire test port with an 84-cell boundary chain.
  Assumes tck comes from the programmer; factoryRst marks manufacture, rst power-up.
*/
`timescale 1ns/10ps
module jcb_config_tap #(
  parameter logic [31:0] IDCODE_VAL = 32'h0A5C3001 // arbitrary value
) (
  input  wire logic                       ref_clk,
  input  wire logic                       rst,
  input  wire logic                       factoryRst,
  input  wire logic                       tck,
  input  wire logic                       tms,
  input  wire logic                       tdi,
  output logic                            tdo,
  output logic                            tdoOe_n,
  input  wire logic [jcb_pkg::IO_N-1:0]   ioIn,
  input  wire logic [jcb_pkg::IO_N-1:0]   ioCoreOut,
  input  wire logic [jcb_pkg::IO_N-1:0]   ioCoreOe,
  input  wire logic [jcb_pkg::DED_N-1:0]  dedIn,
  output logic      [jcb_pkg::IO_N-1:0]   ioOut,
  output logic      [jcb_pkg::IO_N-1:0]   ioOe_n,
  output logic      [jcb_pkg::DR_W-1:0]   activeConfig,
  output logic                            configRunning,
  output logic                            lockout,
  output logic                            securityOn,
  output logic                            liveReprogram,
  output logic                            tapPinsAsIo,
  output logic                            pullupTms,
  output logic                            pullupTdi
);
  ////////////////////////////////////////////////////////////////////////////////
  jcb_pkg::jcb_tck_st_t t_q, t_d;
  jcb_pkg::jcb_ref_st_t r_q, r_d;
  logic        tdo_q, tdoOe_n_q;
  logic        tckRst, tdoSel, rdy, fire, abortEv, ioHighZ, extest, highzIr;
  logic        bndIr, wordIr, ispIr;

  function automatic jcb_pkg::jcb_tap_t nextTap(jcb_pkg::jcb_tap_t s, logic m);
    case (s)
      jcb_pkg::TAP_RESET: nextTap = m ? jcb_pkg::TAP_RESET : jcb_pkg::TAP_IDLE;
      jcb_pkg::TAP_IDLE:  nextTap = m ? jcb_pkg::TAP_SELDR : jcb_pkg::TAP_IDLE;
      jcb_pkg::TAP_SELDR: nextTap = m ? jcb_pkg::TAP_SELIR : jcb_pkg::TAP_CAPDR;
      jcb_pkg::TAP_CAPDR: nextTap = m ? jcb_pkg::TAP_EX1DR : jcb_pkg::TAP_SHDR;
      jcb_pkg::TAP_SHDR:  nextTap = m ? jcb_pkg::TAP_EX1DR : jcb_pkg::TAP_SHDR;
      jcb_pkg::TAP_EX1DR: nextTap = m ? jcb_pkg::TAP_UPDR  : jcb_pkg::TAP_PSDR;
      jcb_pkg::TAP_PSDR:  nextTap = m ? jcb_pkg::TAP_EX2DR : jcb_pkg::TAP_PSDR;
      jcb_pkg::TAP_EX2DR: nextTap = m ? jcb_pkg::TAP_UPDR  : jcb_pkg::TAP_SHDR;
      jcb_pkg::TAP_UPDR:  nextTap = m ? jcb_pkg::TAP_SELDR : jcb_pkg::TAP_IDLE;
      jcb_pkg::TAP_SELIR: nextTap = m ? jcb_pkg::TAP_RESET : jcb_pkg::TAP_CAPIR;
      jcb_pkg::TAP_CAPIR: nextTap = m ? jcb_pkg::TAP_EX1IR : jcb_pkg::TAP_SHIR;
      jcb_pkg::TAP_SHIR:  nextTap = m ? jcb_pkg::TAP_EX1IR : jcb_pkg::TAP_SHIR;
      jcb_pkg::TAP_EX1IR: nextTap = m ? jcb_pkg::TAP_UPIR  : jcb_pkg::TAP_PSIR;
      jcb_pkg::TAP_PSIR:  nextTap = m ? jcb_pkg::TAP_EX2IR : jcb_pkg::TAP_PSIR;
      jcb_pkg::TAP_EX2IR: nextTap = m ? jcb_pkg::TAP_UPIR  : jcb_pkg::TAP_SHIR;
      default:            nextTap = m ? jcb_pkg::TAP_SELDR : jcb_pkg::TAP_IDLE;
    endcase
  endfunction

  // pin cells {oe,out,in}; dedicated input cells capture the pin only, no update
  function automatic logic [jcb_pkg::CHAIN_W-1:0] capVec(
      logic [jcb_pkg::IO_N-1:0] pin, logic [jcb_pkg::IO_N-1:0] out,
      logic [jcb_pkg::IO_N-1:0] oe, logic [jcb_pkg::DED_N-1:0] ded);
    capVec = '0;
    for (int i = 0; i < jcb_pkg::IO_N; i++) begin
      capVec[i*jcb_pkg::CAP_W +: jcb_pkg::CAP_W] = {oe[i], out[i], pin[i]};
    end
    for (int j = 0; j < jcb_pkg::DED_N; j++) begin
      capVec[(jcb_pkg::IO_N+j)*jcb_pkg::CAP_W] = ded[j];
    end
  endfunction

  ////////////////////////////////////////////////////////////////////////////////
  // test clock domain
  assign tckRst  = t_q.rstS2 | ~t_q.tapEnS2;
  assign bndIr   = (t_q.ir == jcb_pkg::IR_EXTEST) | (t_q.ir == jcb_pkg::IR_SAMPLE);
  assign ispIr   = (t_q.ir >= jcb_pkg::IR_ENABLE) & (t_q.ir <= jcb_pkg::IR_SIGRD);
  assign wordIr  = ispIr | (t_q.ir == jcb_pkg::IR_IDCODE);
  assign rdy     = (t_q.ackS2 == t_q.reqTgl);
  assign extest  = (t_q.ir == jcb_pkg::IR_EXTEST);
  assign highzIr = (t_q.ir == jcb_pkg::IR_HIGHZ);

  always_comb begin
    t_d         = t_q;
    t_d.rstS1   = rst;
    t_d.rstS2   = t_q.rstS1;
    t_d.tapEnS1 = r_q.cfg[jcb_pkg::CFG_TAPEN_BIT];
    t_d.tapEnS2 = t_q.tapEnS1;
    t_d.ackS1   = r_q.ackTgl;
    t_d.ackS2   = t_q.ackS1;
    t_d.smp1    = capVec(ioIn, ioCoreOut, ioCoreOe, dedIn);
    t_d.smp2    = t_q.smp1;
    t_d.tap     = nextTap(t_q.tap, tms);
    case (t_q.tap)
      jcb_pkg::TAP_CAPIR: t_d.irSh = jcb_pkg::IR_CAPTURE;
      jcb_pkg::TAP_SHIR:  t_d.irSh = {tdi, t_q.irSh[jcb_pkg::IR_W-1:1]};
      jcb_pkg::TAP_UPIR:  t_d.ir   = t_q.irSh;
      jcb_pkg::TAP_CAPDR: begin
        t_d.byp = 1'b0;
        if (bndIr) t_d.bsr = t_q.smp2;
        if (t_q.ir == jcb_pkg::IR_IDCODE) t_d.dr = IDCODE_VAL;
        if (ispIr) t_d.dr = rdy ? r_q.rdWord : '0;
      end
      jcb_pkg::TAP_SHDR: begin
        t_d.byp = tdi;
        if (bndIr) t_d.bsr = {tdi, t_q.bsr[jcb_pkg::CHAIN_W-1:1]};
        if (wordIr) t_d.dr = {tdi, t_q.dr[jcb_pkg::DR_W-1:1]};
      end
      jcb_pkg::TAP_UPDR: begin
        if (bndIr) begin
          for (int i = 0; i < jcb_pkg::IO_N; i++) begin
            t_d.updOut[i] = t_q.bsr[i*jcb_pkg::CAP_W+1];
            t_d.updOe[i]  = t_q.bsr[i*jcb_pkg::CAP_W+2];
          end
        end
        // a command issued while the last one is unanswered is dropped
        if (ispIr && rdy) begin
          t_d.cmd    = '{op: t_q.ir, data: t_q.dr};
          t_d.reqTgl = ~t_q.reqTgl;
        end
      end
      default: ;
    endcase
    if (t_q.tap == jcb_pkg::TAP_RESET) t_d.ir = jcb_pkg::IR_IDCODE;
    if (t_d.tap == jcb_pkg::TAP_RESET && t_q.tap != jcb_pkg::TAP_RESET) begin
      t_d.abortTgl = ~t_q.abortTgl;
    end
    if (tckRst) begin
      t_d.tap    = jcb_pkg::TAP_RESET;
      t_d.ir     = jcb_pkg::IR_IDCODE;
      t_d.updOut = '0;
      t_d.updOe  = '0;
    end
    // toggles restart only on power-up so that both ends agree on parity
    if (t_q.rstS2) begin
      t_d.reqTgl   = 1'b0;
      t_d.abortTgl = 1'b0;
      t_d.cmd      = '0;
    end
  end

  always_ff @(posedge tck) begin
    t_q <= t_d;
  end

  always_comb begin
    tdoSel = t_q.byp;
    if (t_q.tap == jcb_pkg::TAP_SHIR) tdoSel = t_q.irSh[0];
    else if (bndIr) tdoSel = t_q.bsr[0];
    else if (wordIr) tdoSel = t_q.dr[0];
  end

  // output side changes on the falling edge
  always_ff @(negedge tck) begin
    if (tckRst) begin
      tdo_q     <= 1'b0;
      tdoOe_n_q <= 1'b1;
    end else begin
      tdo_q     <= tdoSel;
      tdoOe_n_q <= ~((t_q.tap == jcb_pkg::TAP_SHIR) | (t_q.tap == jcb_pkg::TAP_SHDR));
    end
  end
  assign tdo     = tdo_q;
  assign tdoOe_n = tdoOe_n_q;

  ////////////////////////////////////////////////////////////////////////////////
  // core clock domain
  assign fire    = r_q.reqS2 != r_q.reqPrev;
  assign abortEv = r_q.abS2 != r_q.abPrev;

  always_comb begin
    r_d         = r_q;
    r_d.reqS1   = t_q.reqTgl;
    r_d.reqS2   = r_q.reqS1;
    r_d.reqPrev = r_q.reqS2;
    r_d.abS1    = t_q.abortTgl;
    r_d.abS2    = r_q.abS1;
    r_d.abPrev  = r_q.abS2;
    case (r_q.core)
      jcb_pkg::CORE_INIT: begin
        r_d.cnt = r_q.cnt + 4'h1;
        if (r_q.cnt == jcb_pkg::INIT_LAST) begin
          r_d.cfg  = r_q.nvMem;
          r_d.core = jcb_pkg::CORE_RUN;
        end
      end
      default: r_d.cnt = '0;
    endcase
    if (fire) begin
      r_d.ackTgl = r_q.reqS2;
      case (t_q.cmd.op)
        jcb_pkg::IR_ENABLE: begin
          r_d.sess   = 1'b1;
          r_d.nvBusy = 1'b1;
          r_d.live_reprogram_mode    = t_q.cmd.data[0];
        end
        jcb_pkg::IR_PROG: begin
          if (r_q.sess) r_d.nvMem = t_q.cmd.data;
        end
        jcb_pkg::IR_DRLOAD: begin
          if (!lockout) r_d.cfg = t_q.cmd.data;
        end
        jcb_pkg::IR_ERASE: begin
          r_d.nvMem  = jcb_pkg::CFG_ERASED;
          r_d.nvSig  = jcb_pkg::SIG_ERASED;
          r_d.nvFuse = 1'b0;
        end
        jcb_pkg::IR_FUSE:  r_d.nvFuse = 1'b1;
        jcb_pkg::IR_DONE: begin
          if (r_q.sess) begin
            r_d.sess   = 1'b0;
            r_d.nvBusy = 1'b0;
            r_d.live_reprogram_mode    = 1'b0;
            r_d.core   = jcb_pkg::CORE_INIT;
            r_d.cnt    = '0;
          end
        end
        jcb_pkg::IR_READ:  r_d.rdWord = r_q.nvFuse ? '0 : r_q.nvMem;
        jcb_pkg::IR_SIGWR: r_d.nvSig  = t_q.cmd.data[jcb_pkg::SIG_W-1:0];
        jcb_pkg::IR_SIGRD: r_d.rdWord = {16'h0000, r_q.nvSig};
        default: ;
      endcase
    end
    if (abortEv) begin
      r_d.sess = 1'b0;
      r_d.live_reprogram_mode  = 1'b0;
    end
    if (rst | factoryRst) begin
      r_d.reqPrev = r_q.reqS2;
      r_d.abPrev  = r_q.abS2;
      r_d.ackTgl  = r_q.reqS2;
      r_d.core    = jcb_pkg::CORE_INIT;
      r_d.cnt     = '0;
      r_d.cfg     = jcb_pkg::CFG_ERASED;
      r_d.rdWord  = '0;
      r_d.sess    = 1'b0;
      r_d.live_reprogram_mode     = 1'b0;
    end
    if (factoryRst) begin
      r_d.nvMem  = jcb_pkg::CFG_ERASED;
      r_d.nvSig  = jcb_pkg::SIG_ERASED;
      r_d.nvFuse = 1'b0;
      r_d.nvBusy = 1'b0;
    end
  end

  always_ff @(posedge ref_clk) begin
    r_q <= r_d;
  end

  // an open session left by power loss or tap reset keeps the part locked
  assign lockout = r_q.nvBusy & ~r_q.sess;
  assign ioHighZ = lockout | (r_q.core == jcb_pkg::CORE_INIT) | (r_q.sess & ~r_q.live_reprogram_mode);

  ////////////////////////////////////////////////////////////////////////////////
  // pin multiplexers are plain gates, as in the physical cell
  always_comb begin
    for (int i = 0; i < jcb_pkg::IO_N; i++) begin
      ioOut[i]  = extest ? t_q.updOut[i] : ioCoreOut[i];
      ioOe_n[i] = (ioHighZ | highzIr) ? 1'b1 : (extest ? ~t_q.updOe[i] : ~ioCoreOe[i]);
    end
  end

  assign activeConfig  = r_q.cfg;
  assign configRunning = (r_q.core == jcb_pkg::CORE_RUN);
  assign securityOn    = r_q.nvFuse;
  assign liveReprogram = r_q.live_reprogram_mode;
  assign tapPinsAsIo   = ~r_q.cfg[jcb_pkg::CFG_TAPEN_BIT];
  assign pullupTms     = r_q.cfg[jcb_pkg::CFG_PUTMS_BIT];
  assign pullupTdi     = r_q.cfg[jcb_pkg::CFG_PUTDI_BIT];

  ////////////////////////////////////////////////////////////////////////////////
  logic readFire, eraseFire, progOtf, drlFire, doneFire;
  assign readFire  = fire & (t_q.cmd.op == jcb_pkg::IR_READ);
  assign eraseFire = fire & (t_q.cmd.op == jcb_pkg::IR_ERASE);
  assign progOtf   = fire & (t_q.cmd.op == jcb_pkg::IR_PROG) & r_q.live_reprogram_mode;
  assign drlFire   = fire & (t_q.cmd.op == jcb_pkg::IR_DRLOAD) & ~lockout;
  assign doneFire  = fire & (t_q.cmd.op == jcb_pkg::IR_DONE) & r_q.sess & ~abortEv;

  sequence initToRun;
    (r_q.core == jcb_pkg::CORE_INIT) ##[1:12] (configRunning && activeConfig == r_q.nvMem);
  endsequence

  a_fuse_blocks_read: assert property (@(posedge ref_clk) disable iff (rst)
    (readFire && r_q.nvFuse) |=> (r_q.rdWord == '0)) else $error("readback leaked with fuse set");
  a_fuse_clear_erase: assert property (@(posedge ref_clk) disable iff (rst)
    $fell(r_q.nvFuse) |-> $past(eraseFire)) else $error("fuse cleared without full erase");
  a_live_keeps_cfg: assert property (@(posedge ref_clk) disable iff (rst)
    progOtf |=> ($stable(activeConfig) && !ioHighZ)) else $error("live reprogram disturbed design");
  a_exit_runs_init: assert property (@(posedge ref_clk) disable iff (rst)
    doneFire |=> initToRun) else $error("init cycle missing after leaving programming");
  a_drl_keeps_nv: assert property (@(posedge ref_clk) disable iff (rst)
    drlFire |=> ($stable(r_q.nvMem) && (activeConfig == $past(t_q.cmd.data))))
    else $error("direct load touched stored image");
  a_power_reload: assert property (@(posedge ref_clk) disable iff (rst)
    $fell(rst) |-> initToRun) else $error("no reload after power-up");
  a_lock_highz: assert property (@(posedge ref_clk) disable iff (rst)
    lockout |-> (&ioOe_n)) else $error("locked part drives a pin");
  a_tap_powerup: assert property (@(posedge tck) disable iff (tckRst)
    $fell(tckRst) |-> (t_q.tap == jcb_pkg::TAP_RESET && t_q.ir == jcb_pkg::IR_IDCODE))
    else $error("tap not reset at power-up");
  a_highz_instr: assert property (@(posedge tck) disable iff (tckRst)
    (t_q.ir == jcb_pkg::IR_HIGHZ) |-> (&ioOe_n)) else $error("highz instruction left a driver");
  a_chain_entry: assert property (@(posedge tck) disable iff (tckRst)
    (t_q.tap == jcb_pkg::TAP_SHDR && bndIr) |=> (t_q.bsr[jcb_pkg::CHAIN_W-1] == $past(tdi)))
    else $error("chain entry not from tdi");
  a_bypass_path: assert property (@(posedge tck) disable iff (tckRst)
    (t_q.tap == jcb_pkg::TAP_SHDR && t_q.ir == jcb_pkg::IR_BYPASS) [*2] |=> (tdoSel == $past(tdi)))
    else $error("bypass path is not one stage");
endmodule // jcb_config_tap

// ---- sim/jcb_jtag_host.sv ----
/*
  Behavioural programmer on the far side of the four-wire test port.
  Assumes the device samples tms/tdi on tck rise and drives tdo on tck fall.
*/
`timescale 1ns/10ps
module jcb_jtag_host (
  output logic      tck,
  output logic      tms,
  output logic      tdi,
  input  wire logic tdo
);
  // tdi idles high, as its optional pull-up would leave it
  initial begin
    tck = 1'b0;
    tms = 1'b1;
    tdi = 1'b1;
  end
  ////////////////////////////////////////////////////////////////////////////
  // one 15 ns period; tck rests low between frames
  task automatic pulse(input logic m, input logic d, output logic o);
    tms = m;
    tdi = d;
    #7.5;
    o = tdo; // read at the rise, device drives it on the fall
    tck = 1'b1;
    #7.5;
    tck = 1'b0;
  endtask
  task automatic run(input logic m, input int n);
    logic o;
    for (int i = 0; i < n; i++) pulse(m, 1'b1, o);
  endtask
  // idle, capture, shift n bits lsb first, update, back to idle
  task automatic scan(input logic ir, input logic [255:0] din, input int n,
                      output logic [255:0] dout);
    logic o;
    dout = '0;
    pulse(1'b1, 1'b1, o);
    if (ir) pulse(1'b1, 1'b1, o);
    pulse(1'b0, 1'b1, o);
    pulse(1'b0, 1'b1, o);
    for (int i = 0; i < n; i++) begin
      pulse(i == n - 1, din[i], o);
      dout[i] = o;
    end
    pulse(1'b1, 1'b1, o);
    pulse(1'b0, 1'b1, o);
  endtask
endmodule // jcb_jtag_host

// ---- sim/jcb_config_tap_test.sv ----
/*
  Self-checking bench for the configuration loader and scan port.
  Assumes the host model owns tck and that nv state survives rst alone.
*/
`timescale 1ns/10ps
module jcb_config_tap_test;
  logic                       ref_clk, rst, factoryRst, tck, tms, tdi, tdo, tdoOe_n;
  logic [jcb_pkg::IO_N-1:0]   ioIn, ioCoreOut, ioCoreOe, ioOut, ioOe_n;
  logic [jcb_pkg::DED_N-1:0]  dedIn;
  logic [31:0]                activeConfig;
  logic                       configRunning, lockout, securityOn, liveReprogram;
  logic                       tapPinsAsIo, pullupTms, pullupTdi;
  logic [255:0]               q;
  int                         errors, samples_checked;
  localparam logic [31:0] ID  = 32'h1234ABCD; // arbitrary value
  localparam logic [31:0] IMG = 32'h5A5AC3C5;

  jcb_config_tap #(.IDCODE_VAL(ID)) uut (.ref_clk(ref_clk), .rst(rst), .factoryRst(factoryRst),
    .tck(tck), .tms(tms), .tdi(tdi), .tdo(tdo), .tdoOe_n(tdoOe_n), .ioIn(ioIn),
    .ioCoreOut(ioCoreOut), .ioCoreOe(ioCoreOe), .dedIn(dedIn), .ioOut(ioOut),
    .ioOe_n(ioOe_n), .activeConfig(activeConfig), .configRunning(configRunning),
    .lockout(lockout), .securityOn(securityOn), .liveReprogram(liveReprogram),
    .tapPinsAsIo(tapPinsAsIo), .pullupTms(pullupTms), .pullupTdi(pullupTdi));
  jcb_jtag_host host (.tck(tck), .tms(tms), .tdi(tdi), .tdo(tdo));

  always #5 ref_clk = ~ref_clk;
  ////////////////////////////////////////////////////////////////////////////
  task automatic check(input logic [255:0] got, input logic [255:0] exp);
    samples_checked++;
    if (got !== exp) begin
      errors++;
      $display("ERROR %0t got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic ir(input logic [3:0] op);
    host.scan(1'b1, {252'h0, op}, 4, q);
  endtask
  task automatic dr(input logic [31:0] d);
    host.scan(1'b0, {224'h0, d}, 32, q);
  endtask
  // idle tck after each command lets the ack cross back before the next one
  task automatic cmd(input logic [3:0] op, input logic [31:0] d);
    ir(op);
    dr(d);
    host.run(1'b0, 12);
  endtask
  // tck keeps running through reset so the test side sees it too
  task automatic power();
    @(negedge ref_clk) rst = 1'b1;
    fork
      repeat (6) @(negedge ref_clk);
      host.run(1'b1, 4);
    join
    @(negedge ref_clk);
    rst = 1'b0;
    factoryRst = 1'b0;
    for (int i = 0; i < 50 && configRunning !== 1'b1; i++) @(negedge ref_clk);
    host.run(1'b1, 5);
    host.run(1'b0, 1);
  endtask
  task automatic complete_run();
    $display("checks %0d errors %0d", samples_checked, errors);
    if (errors == 0 && samples_checked > 0) $display("RESULT: PASS");
    else $display("RESULT: FAIL");
    $finish;
  endtask
  ////////////////////////////////////////////////////////////////////////////
  task automatic s_ident();
    logic o;
    check(activeConfig, 32'hFFFFFFFF);
    check({configRunning, lockout, securityOn, tapPinsAsIo}, 4'b1000);
    host.scan(1'b0, '0, 32, q);
    check(q[31:0], ID);
    ir(jcb_pkg::IR_BYPASS);
    check(q[3:0], 4'h1);
    host.scan(1'b0, 256'h1, 2, q);
    check(q[1:0], 2'b10);
    // park in shift-dr: tdo driven there, released again once back in idle
    host.pulse(1'b1, 1'b1, o);
    host.pulse(1'b0, 1'b1, o);
    host.pulse(1'b0, 1'b1, o);
    #1;
    check(tdoOe_n, 1'b0);
    host.pulse(1'b1, 1'b1, o);
    host.pulse(1'b1, 1'b1, o);
    host.pulse(1'b0, 1'b1, o);
    #1;
    check(tdoOe_n, 1'b1);
  endtask
  task automatic s_scan();
    logic [255:0] e;
    e = '0;
    @(negedge ref_clk);
    ioIn = {5{16'hC35A}};
    ioCoreOut = {5{16'h0FF1}};
    ioCoreOe = {5{16'h6A93}};
    dedIn = 4'h9;
    for (int i = 0; i < 80; i++) e[3*i +: 3] = {ioCoreOe[i], ioCoreOut[i], ioIn[i]};
    for (int i = 0; i < 4; i++) e[240 + 3*i] = dedIn[i];
    ir(jcb_pkg::IR_SAMPLE);
    check({ioOut, ioOe_n}, {ioCoreOut, ~ioCoreOe});
    // overrun by four bits: they must reappear after the whole chain
    host.scan(1'b0, {{42{6'b011100}}, 4'h6}, 256, q);
    check(q, {4'h6, e[251:0]});
    ir(jcb_pkg::IR_EXTEST);
    check({ioOut, ioOe_n}, {{40{2'b10}}, {40{2'b10}}});
    ir(jcb_pkg::IR_HIGHZ);
    check(ioOe_n, {80{1'b1}});
    ir(jcb_pkg::IR_BYPASS);
    check(ioOut, ioCoreOut);
  endtask
  task automatic s_live();
    cmd(jcb_pkg::IR_ENABLE, 32'h1);
    check({liveReprogram, lockout}, 2'b10);
    cmd(jcb_pkg::IR_PROG, IMG);
    check({activeConfig, ioOe_n}, {32'hFFFFFFFF, ~ioCoreOe});
    cmd(jcb_pkg::IR_DONE, 32'h0);
    check(activeConfig, IMG);
    check({configRunning, liveReprogram, pullupTms, pullupTdi}, 4'b1001);
  endtask
  task automatic s_direct();
    cmd(jcb_pkg::IR_DRLOAD, 32'h00000F02);
    check({activeConfig, tapPinsAsIo}, {32'h00000F02, 1'b1});
    power();
    check({activeConfig, tapPinsAsIo}, {IMG, 1'b0});
  endtask
  task automatic s_secure();
    cmd(jcb_pkg::IR_SIGWR, 32'h00003C69);
    cmd(jcb_pkg::IR_READ, 32'h0);
    dr(32'h0);
    check(q[31:0], IMG);
    cmd(jcb_pkg::IR_FUSE, 32'h0);
    check(securityOn, 1'b1);
    cmd(jcb_pkg::IR_READ, 32'h0);
    dr(32'h0);
    check(q[31:0], 32'h0);
    cmd(jcb_pkg::IR_SIGRD, 32'h0);
    dr(32'h0);
    check(q[31:0], 32'h00003C69);
    power();
    check(securityOn, 1'b1);
    cmd(jcb_pkg::IR_ERASE, 32'h0);
    check(securityOn, 1'b0);
    cmd(jcb_pkg::IR_READ, 32'h0);
    dr(32'h0);
    check(q[31:0], 32'hFFFFFFFF);
  endtask
  task automatic s_lock();
    cmd(jcb_pkg::IR_ENABLE, 32'h0);
    check(ioOe_n, {80{1'b1}});
    host.run(1'b1, 5);
    host.run(1'b0, 1);
    repeat (6) @(negedge ref_clk);
    check({lockout, ioOe_n}, {1'b1, {80{1'b1}}});
    // a locked part must refuse a direct register load
    cmd(jcb_pkg::IR_DRLOAD, 32'h00000F02);
    check(activeConfig, IMG);
    cmd(jcb_pkg::IR_ENABLE, 32'h1);
    cmd(jcb_pkg::IR_DONE, 32'h0);
    check({lockout, activeConfig}, {1'b0, 32'hFFFFFFFF});
  endtask
  ////////////////////////////////////////////////////////////////////////////
  initial begin
    ref_clk = 1'b0;
    rst = 1'b1;
    factoryRst = 1'b1;
    ioIn = '0;
    ioCoreOut = '0;
    ioCoreOe = '0;
    dedIn = '0;
    errors = 0;
    samples_checked = 0;
    power();
    s_ident();
    s_scan();
    s_live();
    s_direct();
    s_secure();
    s_lock();
    complete_run();
  end
  // whole run is near 22 us; this cuts a hang well past that
  initial begin
    #300us;
    errors++;
    complete_run();
  end
endmodule // jcb_config_tap_test
